// *** pkg/pul_pkg.sv ***
// shared constants for the power-up lockout and init block
`default_nettype none
package pul_pkg;
    localparam int unsigned PUL_CLOCK_HZ = 100_000_000;
    localparam int unsigned PUL_PROC_CLK_HZ = 80_000;
    // divider count for the 80 kHz processor clock enable
    localparam int unsigned PUL_PROC_DIV = PUL_CLOCK_HZ / PUL_PROC_CLK_HZ;
    // cycles the hardware needs to reach its starting state after reset
    localparam int unsigned PUL_START_CYCLES = 16;
    localparam int unsigned PUL_PHASE_N = 6;
    localparam int unsigned PUL_DUTY_W = 9;
    localparam logic [8:0] PUL_DUTY_FULL = 9'h1FF;
    localparam logic [8:0] PUL_DAC_RST = 9'h000;
    localparam logic [1:0] PUL_PH_RST = 2'h0;
    localparam logic PUL_PWM_SEL_RST = 1'h0;
    localparam logic [3:0] PUL_MON_SEL_RST = 4'h1;
    // port enables come up released, so every pin starts as an input
    localparam logic [7:0] PUL_PORT_RST = 8'hFF;
    localparam int unsigned PUL_WAKE_N = 4;
    typedef enum {PUL_LOCKOUT, PUL_RUN, PUL_STOP} pul_state_e;
endpackage
`default_nettype wire

// *** rtl/pul_duty_scaler.sv ***
// linear map of duty command onto the programmed duty window
`timescale 1ns/1ps
`default_nettype none
module pul_duty_scaler
    import pul_pkg::*;
#(
    parameter int unsigned W = PUL_DUTY_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // limits and command
    input wire logic [W-1:0] dutyMin,
    input wire logic [W-1:0] dutyMax,
    input wire logic [W-1:0] dutyCmd,
    // scaled duty
    output logic [W-1:0] dutyOut
);
    logic [W-1:0] duty_reg;
    logic [W-1:0] duty_next;
    logic [W-1:0] span;
    logic [2*W-1:0] prod;

    always_comb begin
        // an inverted window collapses to the minimum rather than wrapping
        span = (dutyMax > dutyMin) ? W'(dutyMax - dutyMin) : '0;
        prod = span * dutyCmd;
        duty_next = W'(dutyMin + W'(prod / (2*W)'(PUL_DUTY_FULL)));
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            duty_reg <= '0;
        end else begin
            duty_reg <= duty_next;
        end
    end

    assign dutyOut = duty_reg;

    scale_full_a: assert property (@(posedge clock) disable iff (srst)
        dutyCmd == PUL_DUTY_FULL && dutyMax >= dutyMin |=> dutyOut == $past(dutyMax))
        else $error("full command does not give max duty");
    scale_zero_a: assert property (@(posedge clock) disable iff (srst)
        dutyCmd == '0 |=> dutyOut == $past(dutyMin))
        else $error("zero command does not give min duty");
endmodule
`default_nettype wire

// *** rtl/pul_sequencer.sv ***
// power-up lockout, peripheral reset states, processor clock and stop/wake control
`timescale 1ns/1ps
`default_nettype none
module pul_sequencer
    import pul_pkg::*;
#(
    parameter int unsigned PHASES = PUL_PHASE_N,
    parameter int unsigned START_CYCLES = PUL_START_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // firmware controls
    input wire logic [11:0] fwEnable,
    input wire logic fwStopReq,
    input wire logic fwPhaseLoad,
    input wire logic [PHASES-1:0] fwPhaseValue,
    input wire logic [PHASES-1:0] pwmPhase,
    input wire logic [8:0] fwDacValue,
    input wire logic fwPwmSel,
    input wire logic [3:0] fwMonSel,
    input wire logic [7:0] fwPort0Out,
    input wire logic [7:0] fwPort1Out,
    input wire logic [8:0] fwDutyMin,
    input wire logic [8:0] fwDutyMax,
    input wire logic [8:0] dutyCmd,
    // wake sources
    input wire logic wakeComparatorIrq,
    input wire logic uartRxPin,
    input wire logic wakeVinLevelIrq,
    input wire logic wakeProcReset,
    // status and pins
    output logic lockout,
    output logic procRunning,
    output logic procClkEn,
    output logic [PHASES-1:0] phaseSwitchOutputs,
    output logic [7:0] port0Out,
    output logic [7:0] port0OutEnN,
    output logic [7:0] port1Out,
    output logic [7:0] port1OutEnN,
    output logic [11:0] periphEnable,
    output logic brownoutEnable,
    output logic [8:0] dacOut,
    output logic pwmSel,
    output logic [3:0] monSel,
    output logic [8:0] dutyOut
);
    // periphEnable bits: 0 vref,1 refdac,2 fastadc,3 filter,4 pwm,5 blanker,
    // 6 blank dac,7 ilim,8 ocp,9 monadc,10 comparator,11 serial/timers, bit 12-up none
    localparam int unsigned CW = $clog2(PUL_PROC_DIV);
    localparam int unsigned SW = $clog2(START_CYCLES + 1);

    pul_state_e state_reg, state_next;
    logic [SW-1:0] start_reg, start_next;
    logic [CW-1:0] div_reg, div_next;
    logic [11:0] en_reg, en_next;
    logic [PHASES-1:0] ph_reg, ph_next;
    logic phOwned_reg, phOwned_next;
    logic [8:0] dac_reg, dac_next;
    logic pwmSel_reg, pwmSel_next;
    logic [3:0] monSel_reg, monSel_next;
    logic [7:0] p0_reg, p0_next, p1_reg, p1_next;
    logic [2:0] rxSync_reg;
    logic rxLevel_reg, rxLevel_next;
    logic [PHASES-1:0] phOut_reg, phOut_next;
    logic rxFall;
    logic wake;
    logic started;

    // rx comes from a pin: three stages, a new level counts once the last two agree
    // so a one-cycle glitch on the line cannot wake the processor
    assign rxLevel_next = (rxSync_reg[2] == rxSync_reg[1]) ? rxSync_reg[2] : rxLevel_reg;

    // idle line is high; resetting high avoids a false edge after reset
    always_ff @(posedge clock) begin
        if (srst) begin
            rxSync_reg <= 3'h7;
            rxLevel_reg <= 1'b1;
        end else begin
            rxSync_reg <= {rxSync_reg[1:0], uartRxPin};
            rxLevel_reg <= rxLevel_next;
        end
    end
    assign rxFall = rxLevel_reg & ~rxLevel_next;
    assign wake = wakeComparatorIrq | rxFall | wakeVinLevelIrq | wakeProcReset;
    assign started = (start_reg == SW'(START_CYCLES));

    always_comb begin
        state_next = state_reg;
        start_next = start_reg;
        div_next = div_reg;
        en_next = en_reg;
        ph_next = ph_reg;
        phOwned_next = phOwned_reg;
        dac_next = dac_reg;
        pwmSel_next = pwmSel_reg;
        monSel_next = monSel_reg;
        p0_next = p0_reg;
        p1_next = p1_reg;
        if (state_reg != PUL_STOP) begin
            div_next = (div_reg == CW'(PUL_PROC_DIV - 1)) ? '0 : CW'(div_reg + 1'b1);
        end
        case (state_reg)
            PUL_LOCKOUT: begin
                // hold enables, dac, selects, ports and phases at power-up state until hardware settles
                if (!started) begin
                    start_next = SW'(start_reg + 1'b1);
                end else begin
                    state_next = PUL_RUN;
                end
            end
            PUL_RUN: begin
                // peripherals only change by explicit firmware request
                en_next = fwEnable;
                // the dac register holds zero whenever the dac is off
                dac_next = fwEnable[1] ? fwDacValue : PUL_DAC_RST;
                pwmSel_next = fwPwmSel;
                monSel_next = fwMonSel;
                p0_next = fwPort0Out;
                p1_next = fwPort1Out;
                if (fwPhaseLoad) begin
                    ph_next = fwPhaseValue;
                    phOwned_next = 1'b1;
                end
                if (fwStopReq && !wake) begin
                    state_next = PUL_STOP;
                end
            end
            PUL_STOP: begin
                if (wake) begin
                    state_next = PUL_RUN;
                    div_next = '0;
                end
            end
            default: state_next = PUL_LOCKOUT;
        endcase
        // phases are registered from what state and enables hold next cycle
        phOut_next = ph_next;
        if (en_next[4]) begin
            phOut_next = pwmPhase;
        end
        if (state_next == PUL_LOCKOUT) begin
            phOut_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= PUL_LOCKOUT;
            start_reg <= '0;
            div_reg <= '0;
            en_reg <= '0;
            ph_reg <= '0;
            phOwned_reg <= 1'b0;
            dac_reg <= PUL_DAC_RST;
            pwmSel_reg <= PUL_PWM_SEL_RST;
            monSel_reg <= PUL_MON_SEL_RST;
            p0_reg <= PUL_PORT_RST;
            p1_reg <= PUL_PORT_RST;
            phOut_reg <= '0;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
            div_reg <= div_next;
            en_reg <= en_next;
            ph_reg <= ph_next;
            phOwned_reg <= phOwned_next;
            dac_reg <= dac_next;
            pwmSel_reg <= pwmSel_next;
            monSel_reg <= monSel_next;
            p0_reg <= p0_next;
            p1_reg <= p1_next;
            phOut_reg <= phOut_next;
        end
    end

    pul_duty_scaler #(
        .W(9)
    ) u_duty (
        .clock(clock),
        .srst(srst),
        .dutyMin(fwDutyMin),
        .dutyMax(fwDutyMax),
        .dutyCmd(dutyCmd),
        .dutyOut(dutyOut)
    );

    assign lockout = (state_reg == PUL_LOCKOUT);
    assign procRunning = (state_reg == PUL_RUN);
    assign procClkEn = (state_reg != PUL_STOP) && (div_reg == CW'(PUL_PROC_DIV - 1));
    // pwm drives phases only once enabled; firmware value otherwise
    // registered: a pwm change reaches the pins one clock later but glitch-free
    assign phaseSwitchOutputs = phOut_reg;
    assign periphEnable = en_reg;
    assign brownoutEnable = 1'b1;
    // dac output is zero while disabled
    assign dacOut = dac_reg;
    assign pwmSel = pwmSel_reg;
    assign monSel = monSel_reg;
    // open drain: drive only low bits; released (input) while lockout
    assign port0Out = 8'h00;
    assign port1Out = 8'h00;
    assign port0OutEnN = lockout ? 8'hFF : p0_reg;
    assign port1OutEnN = lockout ? 8'hFF : p1_reg;

    lock_hold_a: assert property (@(posedge clock) disable iff (srst)
        lockout |-> phaseSwitchOutputs == '0 && port0OutEnN == 8'hFF && port1OutEnN == 8'hFF)
        else $error("pins not quiet during lockout");
    reset_lock_a: assert property (@(posedge clock) $fell(srst) |->
        lockout && periphEnable == '0)
        else $error("reset did not enter lockout");
    reset_defaults_a: assert property (@(posedge clock) $fell(srst) |->
        dacOut == 9'h000 && pwmSel == 1'b0 && monSel == 4'h1)
        else $error("power-up defaults wrong");
    lock_release_a: assert property (@(posedge clock) disable iff (srst)
        $fell(srst) |-> lockout [*8])
        else $error("lockout released too early");
    lock_exit_a: assert property (@(posedge clock) disable iff (srst)
        lockout && started |=> procRunning)
        else $error("lockout not left after settling");
    lock_defaults_a: assert property (@(posedge clock) disable iff (srst)
        lockout |-> periphEnable == '0 && pwmSel == PUL_PWM_SEL_RST && monSel == PUL_MON_SEL_RST)
        else $error("peripherals left defaults during lockout");
    phase_low_a: assert property (@(posedge clock) disable iff (srst)
        !phOwned_reg && !en_reg[4] |-> phaseSwitchOutputs == '0)
        else $error("phases moved without firmware or pwm");
    phase_pwm_a: assert property (@(posedge clock) disable iff (srst)
        procRunning && fwEnable[4] |=> phaseSwitchOutputs == $past(pwmPhase))
        else $error("enabled pwm not driving the phases");
    clk_rate_a: assert property (@(posedge clock) disable iff (srst)
        procClkEn |=> !procClkEn [*8])
        else $error("processor clock enable too frequent");
    wake_event_a: assert property (@(posedge clock) disable iff (srst)
        state_reg == PUL_STOP && (wakeComparatorIrq || wakeVinLevelIrq || wakeProcReset)
        |=> procRunning)
        else $error("wake event ignored");
    rx_wake_a: assert property (@(posedge clock) disable iff (srst)
        state_reg == PUL_STOP && rxFall |=> procRunning)
        else $error("uart falling edge did not wake");
    stop_enter_a: assert property (@(posedge clock) disable iff (srst)
        procRunning && fwStopReq && !wake |=> state_reg == PUL_STOP)
        else $error("stop request not taken");
    stop_hold_a: assert property (@(posedge clock) disable iff (srst)
        state_reg == PUL_STOP && !wake |=> state_reg == PUL_STOP)
        else $error("stop left without a wake event");
    stop_quiet_a: assert property (@(posedge clock) disable iff (srst)
        state_reg == PUL_STOP |-> !procClkEn)
        else $error("processor clocked in stop");
    periph_follow_a: assert property (@(posedge clock) disable iff (srst)
        procRunning |=> periphEnable == $past(fwEnable))
        else $error("peripheral enables not following firmware");
    dac_follow_a: assert property (@(posedge clock) disable iff (srst)
        procRunning && fwEnable[1] |=> dacOut == $past(fwDacValue))
        else $error("enabled dac not following its value");
    select_follow_a: assert property (@(posedge clock) disable iff (srst)
        procRunning |=> pwmSel == $past(fwPwmSel) && monSel == $past(fwMonSel))
        else $error("selectors not following firmware");
    port_follow_a: assert property (@(posedge clock) disable iff (srst)
        procRunning |=> port0OutEnN == $past(fwPort0Out) && port1OutEnN == $past(fwPort1Out))
        else $error("port enables not following firmware");
    dac_off_a: assert property (@(posedge clock) disable iff (srst)
        !periphEnable[1] |-> dacOut == 9'h000)
        else $error("dac output not zero while off");
    brownout_on_a: assert property (@(posedge clock) disable iff (srst)
        brownoutEnable)
        else $error("brownout detector off");

    enter_run_c: cover property (@(posedge clock) disable iff (srst) $fell(lockout));
    enter_stop_c: cover property (@(posedge clock) disable iff (srst)
        state_reg == PUL_STOP);
    rx_wake_c: cover property (@(posedge clock) disable iff (srst)
        state_reg == PUL_STOP && rxFall);
    phase_load_c: cover property (@(posedge clock) disable iff (srst)
        procRunning && fwPhaseLoad);
    pwm_drive_c: cover property (@(posedge clock) disable iff (srst)
        procRunning && en_reg[4]);
endmodule
`default_nettype wire

// *** tb/pul_fw_model.sv ***
// firmware and wake source model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module pul_fw_model (
    // clock
    input wire logic clock,
    // stop request and wake sources
    output logic stopReq,
    output logic cmpIrq,
    output logic uartRx,
    output logic vinIrq,
    output logic procRst
);
    initial begin
        stopReq = 1'b0;
        cmpIrq = 1'b0;
        uartRx = 1'b1;
        vinIrq = 1'b0;
        procRst = 1'b0;
    end

    // firmware parks the processor once set up, as below undervoltage
    task automatic stop_proc();
        @(negedge clock) stopReq = 1'b1;
        @(negedge clock) stopReq = 1'b0;
    endtask

    // wake source k asserts (uart line goes low for k=1) and stays for six cycles, long enough for the synchroniser
    task automatic wake(input int k);
        @(negedge clock);
        case (k)
            0: cmpIrq = 1'b1;
            1: uartRx = 1'b0;
            2: vinIrq = 1'b1;
            default: procRst = 1'b1;
        endcase
        repeat (6) @(negedge clock);
        {cmpIrq, vinIrq, procRst} = 3'h0;
        uartRx = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb/test_power_up_lockout_init.sv ***
// self-checking bench for the power-up lockout sequencer
`timescale 1ns/1ps
`default_nettype none
module test_power_up_lockout_init;
    import pul_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [11:0] fwEnable = 12'h000;
    logic fwPhaseLoad = 1'b0;
    logic [5:0] fwPhaseValue = 6'h00;
    logic [5:0] pwmPhase = 6'h2A;
    logic [8:0] fwDacValue = 9'h1A5;
    logic fwPwmSel = 1'b0;
    logic [3:0] fwMonSel = 4'h1;
    logic [7:0] fwPort0Out = 8'h00;
    logic [7:0] fwPort1Out = 8'hA5;
    logic [8:0] fwDutyMin = 9'h000, fwDutyMax = 9'h000, dutyCmd = 9'h000;
    wire logic stopReq, cmpIrq, uartRx, vinIrq, procRst;
    logic lockout, procRunning, procClkEn, brownoutEnable, pwmSel;
    logic [5:0] phases;
    logic [7:0] p0Out, p0EnN, p1Out, p1EnN;
    logic [11:0] periphEnable;
    logic [8:0] dacOut, dutyOut;
    logic [3:0] monSel;
    int errors = 0;
    int cmpCount = 0;
    int n;

    always #5 clock = ~clock;

    pul_fw_model fw (.clock(clock), .stopReq(stopReq), .cmpIrq(cmpIrq), .uartRx(uartRx),
        .vinIrq(vinIrq), .procRst(procRst));

    pul_sequencer dut (.clock(clock), .srst(srst), .fwEnable(fwEnable), .fwStopReq(stopReq),
        .fwPhaseLoad(fwPhaseLoad), .fwPhaseValue(fwPhaseValue), .pwmPhase(pwmPhase),
        .fwDacValue(fwDacValue), .fwPwmSel(fwPwmSel), .fwMonSel(fwMonSel),
        .fwPort0Out(fwPort0Out), .fwPort1Out(fwPort1Out), .fwDutyMin(fwDutyMin),
        .fwDutyMax(fwDutyMax), .dutyCmd(dutyCmd), .wakeComparatorIrq(cmpIrq),
        .uartRxPin(uartRx), .wakeVinLevelIrq(vinIrq), .wakeProcReset(procRst),
        .lockout(lockout), .procRunning(procRunning), .procClkEn(procClkEn),
        .phaseSwitchOutputs(phases), .port0Out(p0Out), .port0OutEnN(p0EnN),
        .port1Out(p1Out), .port1OutEnN(p1EnN), .periphEnable(periphEnable),
        .brownoutEnable(brownoutEnable), .dacOut(dacOut), .pwmSel(pwmSel),
        .monSel(monSel), .dutyOut(dutyOut));

    task automatic complete_run();
        if (errors == 0 && cmpCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge clock);
    endtask

    // cycles until the next processor clock enable, capped
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            step(1);
            c++;
        end while (procClkEn !== 1'b1 && c < 2000);
    endtask

    // defaults shared by the reset and lockout checks
    task automatic chk_defaults();
        chk("lockout", lockout, 1'b1);
        chk("phases", phases, 6'h00);
        chk("port0 en", p0EnN, 8'hFF);
        chk("port1 en", p1EnN, 8'hFF);
        chk("port0 out", p0Out, 8'h00);
        chk("port1 out", p1Out, 8'h00);
        chk("periph", periphEnable, 12'h000);
        chk("brownout", brownoutEnable, 1'b1);
        chk("dac", dacOut, PUL_DAC_RST);
        chk("pwm sel", pwmSel, PUL_PWM_SEL_RST);
        chk("mon sel", monSel, PUL_MON_SEL_RST);
    endtask

    initial begin
        step(4);
        chk_defaults();
        chk("duty rst", dutyOut, 9'h000);
        srst = 1'b0;
        // firmware values offered during lockout must not land
        fwEnable = 12'hFFF;
        fwPwmSel = 1'b1;
        step(16);
        chk_defaults();
        step(1);
        chk("lockout end", lockout, 1'b0);
        chk("port0 settle", p0EnN, 8'hFF);
        step(2);
        chk("periph on", periphEnable, 12'hFFF);
        chk("port0 drive", p0EnN, 8'h00);
        chk("port1 drive", p1EnN, 8'hA5);
        chk("pwm phases", phases, 6'h2A);
        chk("dac on", dacOut, 9'h1A5);
        chk("pwm sel run", pwmSel, 1'b1);
        fwEnable = 12'h000;
        fwMonSel = 4'h7;
        step(2);
        chk("phase hold", phases, 6'h00);
        chk("dac off", dacOut, 9'h000);
        chk("mon sel run", monSel, 4'h7);
        fwPhaseValue = 6'h15;
        fwPhaseLoad = 1'b1;
        step(1);
        fwPhaseLoad = 1'b0;
        step(1);
        chk("phase load", phases, 6'h15);
        wait_tick(n);
        wait_tick(n);
        chk("proc tick", n, 16'd1250);
        for (int k = 0; k < PUL_WAKE_N; k++) begin
            fw.stop_proc();
            chk("stopped", procRunning, 1'b0);
            n = 0;
            repeat (1300) begin
                step(1);
                if (procClkEn === 1'b1)
                    n++;
            end
            chk("stop ticks", n, 16'd0);
            fork
                fw.wake(k);
            join_none
            n = 0;
            do begin
                step(1);
                n++;
            end while (procRunning !== 1'b1 && n < 8);
            chk("woken", procRunning, 1'b1);
            step(8);
        end
        // a second reset in mid-run must restore every power-up state
        srst = 1'b1;
        step(2);
        chk_defaults();
        srst = 1'b0;
        step(17);
        chk("relock end", lockout, 1'b0);
        chk("phase cleared", phases, 6'h00);
        chk("mon sel held", monSel, PUL_MON_SEL_RST);
        chk("port1 settle", p1EnN, 8'hFF);
        // min, max, command and the floor of the linear map
        fwDutyMin = 9'h064;
        fwDutyMax = 9'h12C;
        step(2);
        chk("duty zero", dutyOut, 9'h064);
        dutyCmd = PUL_DUTY_FULL;
        step(2);
        chk("duty full", dutyOut, 9'h12C);
        dutyCmd = 9'h100;
        step(2);
        chk("duty mid", dutyOut, 9'h0C8);
        fwDutyMin = 9'h12C;
        fwDutyMax = 9'h064;
        step(2);
        chk("duty swap", dutyOut, 9'h12C);
        complete_run();
    end

    initial begin
        #500_000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
